/* hw/gpcd_pkg.sv */
/*
 Package for the port group C/D data register block: register indices,
 field widths, reset values, bus timing and the packed carriers.
 Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
*/
package gpcd_pkg;
   localparam int          REG_W       = 16;
   localparam int          GRP_C_W     = 5;
   localparam int          GRP_D_W     = 14;
   localparam int          AXI_DATA_W  = 32;
   localparam int          AXI_ADDR_W  = 12;
   // Printed offsets are not word aligned, so they serve as word indices
   localparam logic [31:0] IDX_GRP_C   = 32'hFFFFF73E;
   localparam logic [31:0] IDX_GRP_D   = 32'hFFFFF746;
   localparam logic [33:0] ADDR_GRP_C  = {IDX_GRP_C, 2'h0};
   localparam logic [33:0] ADDR_GRP_D  = {IDX_GRP_D, 2'h0};
   localparam logic [15:0] REG_RESET   = 16'h0000;
   localparam int          ACC_CYCLES  = 4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SEL_NONE, SEL_C, SEL_D} gpcd_sel_e;

   // Per-pin settings from the pin function controller
   typedef struct packed {
      logic [REG_W-1:0] dir;
      logic [REG_W-1:0] gen_out;
   } gpcd_cfg_s;

   typedef struct packed {
      logic [AXI_ADDR_W-1:0]   addr;
      logic [AXI_DATA_W-1:0]   data;
      logic [AXI_DATA_W/8-1:0] strb;
   } gpcd_wreq_s;
endpackage

/* hw/gpcd_data_regs.sv */
/*
 Data registers and pin logic for general-purpose port groups C and D,
 reached over an AXI4-Lite slave.
 Assumes pin inputs synchronous-capable to aclk after two flops, and a
 pin function controller that supplies direction and function per pin.
*/
// Our own choice: the AXI4-Lite register port.
// What this block does
// - Group C has five two-way pins on data bits 4 to 0.
// - Group D has fourteen two-way pins on data bits 13 to 0.
// - Each data register is sixteen bits, read/write, holding pin output data.
// - Every access completes in a fixed four cycles, whatever its size.
// - Group C bits 15 to 5 read zero; software writes zero there.
// - Group D bits 15 and 14 read zero; software writes zero there.
// - General output pin: written value is stored and driven on the pin.
// - General output pin: read returns the stored value, not the pin.
// - General input pin: read returns the live pin level.
// - General input pin: write stores the bit, pin unaffected.
// - Direction 0 reads pin level even when a peripheral uses the pin.
// - Direction 1 with peripheral function reads the stored value.
// - Pins not acting as general output are never driven by writes.
// - Power-on reset and hardware standby clear both registers; watchdog does not.
// - Registers hold their contents through software standby and sleep.
// - Group D bits map one-to-one to pins 13 down to 0.
// - Pin function and direction come from the pin function controller.
`timescale 1ns/1ps
module gpcd_data_regs #(
   parameter int C_W    = gpcd_pkg::GRP_C_W,
   parameter int D_W    = gpcd_pkg::GRP_D_W,
   parameter int ADDR_W = gpcd_pkg::AXI_ADDR_W
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  hw_standby,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire gpcd_pkg::gpcd_cfg_s   grp_c_cfg,
   input  wire gpcd_pkg::gpcd_cfg_s   grp_d_cfg,
   input  wire logic [C_W-1:0]        grp_c_pin_in,
   output logic [C_W-1:0]             grp_c_pin_out,
   output logic [C_W-1:0]             grp_c_pin_oe,
   input  wire logic [D_W-1:0]        grp_d_pin_in,
   output logic [D_W-1:0]             grp_d_pin_out,
   output logic [D_W-1:0]             grp_d_pin_oe
);
   import gpcd_pkg::*;

   typedef enum {WR_IDLE, WR_WAIT, WR_RESP} gpcd_wr_e;
   typedef enum {RD_IDLE, RD_WAIT, RD_RESP} gpcd_rd_e;

   // The captured write address is a package-width field, so the port
   // width must match it or the decode would silently lose bits
   if (C_W < 1 || C_W > REG_W || D_W < 1 || D_W > REG_W ||
       ADDR_W != AXI_ADDR_W || ACC_CYCLES < 3) begin : g_chk
      $error("gpcd_data_regs: unsupported width or timing");
   end

   localparam logic [2:0] WR_LOAD = 3'(ACC_CYCLES - 2);
   localparam logic [2:0] RD_LOAD = 3'(ACC_CYCLES - 1);

   // Only the low address bits are decoded; the block sits in a small window
   function automatic gpcd_sel_e addr_sel(input logic [ADDR_W-1:0] a);
      if (a == ADDR_GRP_C[ADDR_W-1:0]) begin
         return SEL_C;
      end else if (a == ADDR_GRP_D[ADDR_W-1:0]) begin
         return SEL_D;
      end
      return SEL_NONE;
   endfunction

   // Direction 1 shows the stored bit, direction 0 the pin, whatever the function
   function automatic logic [REG_W-1:0] rd_mix(input logic [REG_W-1:0] st,
                                               input logic [REG_W-1:0] dir,
                                               input logic [REG_W-1:0] pin);
      return (dir & st) | (~dir & pin);
   endfunction

   // Strobes above the register's two lanes have nothing to touch
   function automatic logic [REG_W-1:0] lane_wr(input logic [REG_W-1:0] old,
                                                input logic [REG_W-1:0] nw,
                                                input logic [3:0] strb);
      logic [REG_W-1:0] r;
      r = old;
      for (int i = 0; i < REG_W; i++) begin
         if (strb[i/8]) begin
            r[i] = nw[i];
         end
      end
      return r;
   endfunction

   gpcd_wr_e          wr_st_r;
   gpcd_rd_e          rd_st_r;
   logic              aw_got_r;
   logic              w_got_r;
   gpcd_wreq_s        wreq_r;
   logic [2:0]        wcnt_r;
   logic [2:0]        rcnt_r;
   logic [ADDR_W-1:0] raddr_r;
   logic [C_W-1:0]    c_data_r;
   logic [D_W-1:0]    d_data_r;
   logic [C_W-1:0]    c_sync1_r;
   logic [C_W-1:0]    c_sync2_r;
   logic [D_W-1:0]    d_sync1_r;
   logic [D_W-1:0]    d_sync2_r;
   logic              wr_fire;
   gpcd_sel_e         wsel;
   gpcd_sel_e         rsel;
   logic [REG_W-1:0]  c_wide;
   logic [REG_W-1:0]  d_wide;

   // The wait starts only once both halves of the write are held
   assign wr_fire = (wr_st_r == WR_IDLE) && aw_got_r && w_got_r;
   assign wsel    = addr_sel(wreq_r.addr);
   assign rsel    = addr_sel(raddr_r);
   assign c_wide  = lane_wr(REG_W'(c_data_r), wreq_r.data[REG_W-1:0],
                            wreq_r.strb);
   assign d_wide  = lane_wr(REG_W'(d_data_r), wreq_r.data[REG_W-1:0],
                            wreq_r.strb);

   // Write channel: address and data taken in either order, then a fixed wait
   // Ready falls once a channel is taken so no second beat slips in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st_r       <= WR_IDLE;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         wreq_r        <= '0;
         wcnt_r        <= 3'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         unique case (wr_st_r)
            WR_IDLE: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  aw_got_r      <= 1'b1;
                  wreq_r.addr   <= s_axi_awaddr;
                  s_axi_awready <= 1'b0;
               end else begin
                  s_axi_awready <= !aw_got_r;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  w_got_r      <= 1'b1;
                  wreq_r.data  <= s_axi_wdata;
                  wreq_r.strb  <= s_axi_wstrb;
                  s_axi_wready <= 1'b0;
               end else begin
                  s_axi_wready <= !w_got_r;
               end
               if (wr_fire) begin
                  wr_st_r <= WR_WAIT;
                  wcnt_r  <= WR_LOAD;
               end
            end
            WR_WAIT: begin
               if (wcnt_r == 3'h0) begin
                  wr_st_r      <= WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
               end else begin
                  wcnt_r <= wcnt_r - 3'h1;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wr_st_r      <= WR_IDLE;
                  s_axi_bvalid <= 1'b0;
                  aw_got_r     <= 1'b0;
                  w_got_r      <= 1'b0;
               end
            end
         endcase
      end
   end

   // Stored data; only reset and hardware standby clear it, low-power modes
   // have no input here so contents simply persist
   // Standby wins over a write landing in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || hw_standby) begin
         c_data_r <= C_W'(REG_RESET);
         d_data_r <= D_W'(REG_RESET);
      end else if (wr_fire) begin
         // Upper bits are not stored, so they always read back zero
         if (wsel == SEL_C) begin
            c_data_r <= c_wide[C_W-1:0];
         end
         if (wsel == SEL_D) begin
            d_data_r <= d_wide[D_W-1:0];
         end
      end
   end

   // Pin drivers lag the register by one cycle so outputs come from flops
   // Peripheral pins get no enable here; the outer pin mux drives them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         grp_c_pin_out <= '0;
         grp_c_pin_oe  <= '0;
         grp_d_pin_out <= '0;
         grp_d_pin_oe  <= '0;
      end else begin
         grp_c_pin_out <= c_data_r;
         grp_d_pin_out <= d_data_r;
         // Enabled only for direction 1 with general-output function
         grp_c_pin_oe  <= grp_c_cfg.dir[C_W-1:0] &
                          grp_c_cfg.gen_out[C_W-1:0];
         grp_d_pin_oe  <= grp_d_cfg.dir[D_W-1:0] &
                          grp_d_cfg.gen_out[D_W-1:0];
      end
   end

   // Two-flop synchronisers on the pin levels
   // Only the second flop feeds the read path; the first may be metastable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_sync1_r <= '0;
         c_sync2_r <= '0;
         d_sync1_r <= '0;
         d_sync2_r <= '0;
      end else begin
         c_sync1_r <= grp_c_pin_in;
         c_sync2_r <= c_sync1_r;
         d_sync1_r <= grp_d_pin_in;
         d_sync2_r <= d_sync1_r;
      end
   end

   // Read channel: fixed latency, data sampled in the cycle it is returned
   // Unmapped reads return zero with an error response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_r       <= RD_IDLE;
         rcnt_r        <= 3'h0;
         raddr_r       <= '0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         unique case (rd_st_r)
            RD_IDLE: begin
               if (s_axi_arvalid && s_axi_arready) begin
                  raddr_r       <= s_axi_araddr;
                  s_axi_arready <= 1'b0;
                  rcnt_r        <= RD_LOAD;
                  rd_st_r       <= RD_WAIT;
               end else begin
                  s_axi_arready <= 1'b1;
               end
            end
            RD_WAIT: begin
               if (rcnt_r == 3'h0) begin
                  rd_st_r      <= RD_RESP;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp  <= RESP_OKAY;
                  unique case (rsel)
                     SEL_C: s_axi_rdata <= 32'(rd_mix(REG_W'(c_data_r),
                        grp_c_cfg.dir & REG_W'({C_W{1'b1}}),
                        REG_W'(c_sync2_r)));
                     SEL_D: s_axi_rdata <= 32'(rd_mix(REG_W'(d_data_r),
                        grp_d_cfg.dir & REG_W'({D_W{1'b1}}),
                        REG_W'(d_sync2_r)));
                     SEL_NONE: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                     end
                  endcase
               end else begin
                  rcnt_r <= rcnt_r - 3'h1;
               end
            end
            RD_RESP: begin
               if (s_axi_rready) begin
                  rd_st_r      <= RD_IDLE;
                  s_axi_rvalid <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule

/* test/gpcd_checker.sv */
/*
 Concurrent checks on the port group C/D data register block.
 Assumes the master offers write address and write data together.
*/
`timescale 1ns/1ps
module gpcd_checker #(
   parameter int C_W    = 5,
   parameter int D_W    = 14,
   parameter int ADDR_W = 12
) (
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic [ADDR_W-1:0]   s_axi_araddr,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire gpcd_pkg::gpcd_cfg_s grp_c_cfg,
   input wire gpcd_pkg::gpcd_cfg_s grp_d_cfg,
   input wire logic [C_W-1:0]      grp_c_pin_oe,
   input wire logic [D_W-1:0]      grp_d_pin_oe
);
   import gpcd_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic ar_c_r;
   // Remembers which register the read in flight addressed
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ar_c_r <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
         ar_c_r <= (s_axi_araddr == ADDR_GRP_C[ADDR_W-1:0]);
   end
   a_read_latency: assert property (
      s_axi_arvalid && s_axi_arready |=>
      !s_axi_rvalid [*4] ##1 s_axi_rvalid)
      else $error("read answer not four cycles after address");
   a_write_latency: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_bvalid [*4] ##1 s_axi_bvalid)
      else $error("write answer not four cycles after request");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   a_oe_grp_c: assert property (
      $past(aresetn) |-> grp_c_pin_oe ==
      $past(grp_c_cfg.dir[C_W-1:0] & grp_c_cfg.gen_out[C_W-1:0]))
      else $error("group c drive enable wrong");
   a_oe_grp_d: assert property (
      $past(aresetn) |-> grp_d_pin_oe ==
      $past(grp_d_cfg.dir[D_W-1:0] & grp_d_cfg.gen_out[D_W-1:0]))
      else $error("group d drive enable wrong");
   a_resv_grp_c: assert property (
      s_axi_rvalid && ar_c_r |-> s_axi_rdata[31:5] == 27'h0)
      else $error("group c reserved bits not zero");
   a_resv_grp_d: assert property (
      s_axi_rvalid && !ar_c_r |-> s_axi_rdata[31:14] == 18'h0)
      else $error("group d reserved bits not zero");
endmodule

bind gpcd_data_regs gpcd_checker #(.C_W(C_W), .D_W(D_W), .ADDR_W(ADDR_W))
   u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .grp_c_cfg, .grp_d_cfg, .grp_c_pin_oe,
   .grp_d_pin_oe);

/* test/gpcd_pin_partner.sv */
/*
 External circuitry on one port group: follows the pin where the block
 drives it, else shows the level chosen by the bench.
*/
`timescale 1ns/1ps
module gpcd_pin_partner #(
   parameter int W = 5
) (
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] ext,
   output logic [W-1:0]     pin_in
);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

/* test/tb_top.sv */
/*
 Bench for the group C/D data registers: AXI4-Lite master, pin partners
 and a read scoreboard. Assumes the 12-bit address decode.
*/
`timescale 1ns/1ps
module tb_top;
   import gpcd_pkg::*;
   localparam logic [11:0] AC = ADDR_GRP_C[11:0];
   localparam logic [11:0] AD = ADDR_GRP_D[11:0];
   logic        aclk = 0, aresetn = 0, hw_standby = 0;
   logic [11:0] aw_a = 0, ar_a = 0;
   logic [31:0] w_d = 0, r_d, rnd = 32'hE002;
   logic [3:0]  w_s = 0;
   logic        aw_v = 0, w_v = 0, b_rdy = 0, ar_v = 0, r_rdy = 0;
   logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
   logic [1:0]  b_r, r_r;
   gpcd_cfg_s   cfg [2] = '{'1, '1};
   logic [4:0]  c_in, c_out, c_oe, ext_c = 0;
   logic [13:0] d_in, d_out, d_oe, ext_d = 0;
   logic [15:0] st [2] = '{0, 0}, pin [2], msk [2] = '{16'h001F, 16'h3FFF};
   logic [33:0] exp_q [$];
   int          fails = 0, n_checks = 0;
   // Slow answers keep ready low until valid shows, to reach the hold checks
   bit          slow = 0;
   logic [15:0] wv;
   always #5 aclk = ~aclk;
   gpcd_data_regs uut (.aclk(aclk), .aresetn(aresetn),
      .hw_standby(hw_standby), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
      .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_r),
      .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a),
      .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
      .s_axi_rresp(r_r), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
      .grp_c_cfg(cfg[0]), .grp_d_cfg(cfg[1]), .grp_c_pin_in(c_in),
      .grp_c_pin_out(c_out), .grp_c_pin_oe(c_oe), .grp_d_pin_in(d_in),
      .grp_d_pin_out(d_out), .grp_d_pin_oe(d_oe));
   gpcd_pin_partner #(.W(5)) u_pc (.pin_out(c_out), .pin_oe(c_oe),
      .ext(ext_c), .pin_in(c_in));
   gpcd_pin_partner #(.W(14)) u_pd (.pin_out(d_out), .pin_oe(d_oe),
      .ext(ext_d), .pin_in(d_in));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Direction 1 reads the stored bit, direction 0 the pin level
   function automatic logic [33:0] ex(input int g);
      return {18'h0, ((cfg[g].dir & st[g]) | (~cfg[g].dir & pin[g])) & msk[g]};
   endfunction
   task check(input string nm, input logic [33:0] seen, input logic [33:0] e);
      n_checks++;
      if (seen !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task complete_run;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic [1:0] e);
      bit pa, pw;
      pa = 1;
      pw = 1;
      @(posedge aclk);
      aw_a <= a;
      w_d <= d;
      w_s <= s;
      aw_v <= 1;
      w_v <= 1;
      b_rdy <= !slow;
      while (pa || pw) begin
         @(posedge aclk);
         pa = pa && !aw_rdy;
         pw = pw && !w_rdy;
         aw_v <= pa;
         w_v <= pw;
      end
      do @(posedge aclk); while (!b_v);
      if (slow) begin
         b_rdy <= 1;
         @(posedge aclk);
      end
      b_rdy <= 0;
      check("bresp", 34'(b_r), 34'(e));
   endtask
   task rd(input logic [11:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      @(posedge aclk);
      ar_a <= a;
      ar_v <= 1;
      r_rdy <= !slow;
      do @(posedge aclk); while (!ar_rdy);
      ar_v <= 0;
      do @(posedge aclk); while (!r_v);
      if (slow) begin
         r_rdy <= 1;
         @(posedge aclk);
      end
      r_rdy <= 0;
   endtask
   task rd_both;
      rd(AC, ex(0));
      rd(AD, ex(1));
   endtask
   always @(posedge aclk) begin
      if (r_v && r_rdy)
         check("rdata", {r_r, r_d}, exp_q.pop_front());
   end
   initial begin
      // Far beyond the few hundred cycles the sequence needs
      #100000;
      fails++;
      complete_run;
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rd_both;
      for (int i = 0; i < 16; i++) begin
         slow = i[1];
         rnd = xs(rnd);
         cfg[0] <= rnd;
         cfg[1] <= {rnd[15:0], rnd[31:16]};
         rnd = xs(rnd);
         ext_c <= rnd[4:0];
         ext_d <= rnd[29:16];
         pin[0] = 16'(rnd[4:0]);
         pin[1] = 16'(rnd[29:16]);
         rnd = xs(rnd);
         wv = rnd[15:0] & msk[i%2];
         wr(i[0] ? AD : AC, 32'(wv), rnd[7:4], RESP_OKAY);
         st[i%2] = {rnd[5] ? rnd[15:8] : st[i%2][15:8],
                    rnd[4] ? rnd[7:0] : st[i%2][7:0]} & msk[i%2];
         check("c_pin_out", 34'(c_out), 34'(st[0][4:0]));
         check("d_pin_out", 34'(d_out), 34'(st[1][13:0]));
         rd_both;
      end
      wr(12'h004, 32'hFFFF, 4'hF, RESP_SLVERR);
      rd(12'h004, {RESP_SLVERR, 32'h0});
      rd_both;
      cfg[0] <= '1;
      cfg[1] <= '1;
      for (int k = 0; k < 2; k++) begin
         wr(AD, 32'h3FFF, 4'h3, RESP_OKAY);
         if (k == 0) begin
            hw_standby <= 1;
            @(posedge aclk);
            hw_standby <= 0;
         end else begin
            aresetn <= 0;
            repeat (8) @(posedge aclk);
            aresetn <= 1;
         end
         repeat (2) @(posedge aclk);
         st[0] = 16'h0;
         st[1] = 16'h0;
         check("d_pin_out", 34'(d_out), 34'h0);
         rd_both;
      end
      repeat (2) @(posedge aclk);
      complete_run;
   end
endmodule
